// ---- core/pwm_cfg_consts.svh ----
/*
 * constants for the pwm indirect configuration block: bus offsets, field
 * positions, reset values and counts.
 * assumes it is included by bare name from the package and the design files.
 */
// Notes on behaviour
// - a window access with channel select up to nine and word select 00b or 01b goes to the local word named by the selects.
// - each channel owns its own words and a window access touches only the chosen channel.
// - word select 00b reaches the duty cycle word, 01b the configuration word.
// - the duty comparison uses only the low N bits, N being the channel's resolution.
// - configuration bit 15 set inverts the output of a running channel; a stopped channel stays low.
// - channels 0 to 7 drive the dac-shared pins unless bit 13 moves them to the alternate pins.
// - a channel runs only while its bit 12 enable and the master enable are both set.
// - configuration bits 9:8 choose the counting clock of each channel on its own.
// - resolution code in bits 3:0 gives 7 bits at 0000b, one more per step, 16 from 1001b up.
`ifndef PWM_CFG_CONSTS_SVH
`define PWM_CFG_CONSTS_SVH

// ***************************************************************
// bus map (byte offsets, low address byte decoded)
// ***************************************************************
`define PWM_ADDR_CTRL 8'h00
`define PWM_ADDR_WINDOW 8'h04
`define PWM_ADDR_STATUS 8'h08

// ***************************************************************
// unit control register fields
// ***************************************************************
`define CTRL_REG_SEL_LSB 0
`define CTRL_CHAN_SEL_LSB 4
`define CTRL_MASTER_EN_BIT 8

// ***************************************************************
// local word selects and configuration word fields
// ***************************************************************
`define SEL_DUTY 2'h0
`define SEL_CONFIG 2'h1
`define CFG_POLARITY_BIT 15
`define CFG_ALTERNATE_PIN_LOCATION_BIT 13
`define CFG_ENABLE_BIT 12
`define CFG_CLK_SRC_LSB 8
`define CFG_DEPTH_LSB 0
`define CLK_SRC_CORE 2'h0
`define CLK_SRC_PERIPH 2'h1

// ***************************************************************
// counts and reset values
// ***************************************************************
`define NUM_CH 10
`define NUM_DAC_CH 8
`define CHAN_LIMIT 4'h9
`define DEPTH_MIN_BITS 5'h07
`define DEPTH_MAX_BITS 5'h10
`define DEPTH_MAX_CODE 4'h9
`define WORD_RESET 16'h0000

`endif

// ---- core/pwm_cfg_pkg.sv ----
/*
 * types shared by the pwm indirect configuration block and its channels.
 * assumes the constants header is on the include path.
 */
`include "pwm_cfg_consts.svh"
`default_nettype none

package pwm_cfg_pkg;

   // ***************************************************************
   // state of the top module
   // ***************************************************************
   typedef struct packed {
      logic [`NUM_CH-1:0][15:0] duty;
      logic [`NUM_CH-1:0][15:0] cfg;
      logic [3:0] chan_sel;
      logic [1:0] reg_sel;
      logic master_en;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic [2:0] ext_sync;
      logic [`NUM_CH-1:0] pin;
      logic [`NUM_DAC_CH-1:0] alt_pin;
   } top_state_type;

   // ***************************************************************
   // state of one channel
   // ***************************************************************
   typedef struct packed {
      logic [15:0] count;
      logic out;
   } chan_state_type;

   // mask of the active duty bits for a resolution code
   function automatic logic [15:0] depth_mask(input logic [3:0] code);
      logic [4:0] bits;
      bits = (code >= `DEPTH_MAX_CODE) ? `DEPTH_MAX_BITS : ({1'b0, code} + `DEPTH_MIN_BITS);
      depth_mask = 16'hffff >> (`DEPTH_MAX_BITS - bits);
   endfunction

endpackage

`default_nettype wire

// ---- core/pwm_cfg_top.sv ----
/*
 * ahb-lite slave holding the unit control register, the indirect window to
 * each channel's duty and configuration words, and a status word of the wave
 * levels; ten channels and pin steering.
 * assumes a single ahb-lite master, word transfers only, ext_clk_pin async.
 */
// Our own choices: the AHB-Lite register port and the register offsets.
`include "pwm_cfg_consts.svh"
`default_nettype none

module pwm_cfg_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // counting sources
   input wire logic periph_tick,
   input wire logic ext_clk_pin,
   // pins
   output logic [`NUM_CH-1:0] pwm_pin,
   output logic [`NUM_DAC_CH-1:0] pwm_alt_pin
);

   pwm_cfg_pkg::top_state_type s_reg, s_next;
   logic [`NUM_CH-1:0] wave;
   logic ext_tick;
   logic take;
   logic chan_ok;
   logic win_wr;
   logic win_rd;

   // ***************************************************************
   // channels
   // ***************************************************************
   // a rising edge of the synchronised external clock counts as one tick
   assign ext_tick = s_reg.ext_sync[1] & ~s_reg.ext_sync[2];

   // every channel sees the same enable and tick sources; only its words differ
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_ch
         pwm_channel u_ch (
            .hclk(hclk),
            .hresetn(hresetn),
            .duty(s_reg.duty[gi]),
            .cfg(s_reg.cfg[gi]),
            .master_en(s_reg.master_en),
            .periph_tick(periph_tick),
            .ext_tick(ext_tick),
            .wave(wave[gi])
         );
      end
   endgenerate

   // ***************************************************************
   // bus, window and pin steering
   // ***************************************************************
   // writes land first so a read right behind a write sees the new word
   always_comb begin
      s_next = s_reg;
      take = hsel & htrans[1] & hready;
      chan_ok = s_reg.chan_sel <= `CHAN_LIMIT;
      win_wr = s_reg.wr_pend && (s_reg.wr_addr == `PWM_ADDR_WINDOW) && chan_ok;
      win_rd = 1'b0;
      s_next.ext_sync = {s_reg.ext_sync[1:0], ext_clk_pin};
      s_next.ready = 1'b1;
      if (s_reg.wr_pend && (s_reg.wr_addr == `PWM_ADDR_CTRL)) begin
         s_next.reg_sel = hwdata[`CTRL_REG_SEL_LSB +: 2];
         s_next.chan_sel = hwdata[`CTRL_CHAN_SEL_LSB +: 4];
         s_next.master_en = hwdata[`CTRL_MASTER_EN_BIT];
      end
      // only the chosen channel's chosen word changes; word selects 10b and
      // 11b and channels above nine drop the write
      if (win_wr) begin
         if (s_reg.reg_sel == `SEL_DUTY) begin
            s_next.duty[s_reg.chan_sel] = hwdata[15:0];
         end else if (s_reg.reg_sel == `SEL_CONFIG) begin
            s_next.cfg[s_reg.chan_sel] = hwdata[15:0];
         end
      end
      s_next.wr_pend = take & hwrite;
      s_next.wr_addr = haddr[7:0];
      s_next.rdata = 32'h0000_0000;
      if (take && !hwrite) begin
         unique case (haddr[7:0])
            `PWM_ADDR_CTRL: begin
               s_next.rdata[`CTRL_REG_SEL_LSB +: 2] = s_next.reg_sel;
               s_next.rdata[`CTRL_CHAN_SEL_LSB +: 4] = s_next.chan_sel;
               s_next.rdata[`CTRL_MASTER_EN_BIT] = s_next.master_en;
            end
            `PWM_ADDR_WINDOW: begin
               win_rd = s_next.chan_sel <= `CHAN_LIMIT;
               // reads leave the word untouched
               if (win_rd && (s_next.reg_sel == `SEL_DUTY)) begin
                  s_next.rdata[15:0] = s_next.duty[s_next.chan_sel];
               end else if (win_rd && (s_next.reg_sel == `SEL_CONFIG)) begin
                  s_next.rdata[15:0] = s_next.cfg[s_next.chan_sel];
               end
            end
            `PWM_ADDR_STATUS: s_next.rdata[`NUM_CH-1:0] = wave;
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end
      // pin steering; the unused location of a channel stays low
      for (int i = 0; i < `NUM_CH; i++) begin
         if (i < `NUM_DAC_CH) begin
            s_next.pin[i] = wave[i] & ~s_reg.cfg[i][`CFG_ALTERNATE_PIN_LOCATION_BIT];
            s_next.alt_pin[i] = wave[i] & s_reg.cfg[i][`CFG_ALTERNATE_PIN_LOCATION_BIT];
         end else begin
            s_next.pin[i] = wave[i];
         end
      end
   end

   // state register; all local words clear on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // no wait states: the slave never stalls, so ready is a flop held high
   assign hreadyout = s_reg.ready;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign pwm_pin = s_reg.pin;
   assign pwm_alt_pin = s_reg.alt_pin;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_win_duty;
      @(posedge hclk) disable iff (!hresetn)
      (win_wr && s_reg.reg_sel == 2'h0)
         |=> s_reg.duty[$past(s_reg.chan_sel)] == $past(hwdata[15:0]);
   endproperty
   a_win_duty: assert property (p_win_duty) else $error("duty word not written");

   property p_win_cfg;
      @(posedge hclk) disable iff (!hresetn)
      (win_wr && s_reg.reg_sel == 2'h1)
         |=> s_reg.cfg[$past(s_reg.chan_sel)] == $past(hwdata[15:0]);
   endproperty
   a_win_cfg: assert property (p_win_cfg) else $error("config word not written");

   property p_other_chan;
      @(posedge hclk) disable iff (!hresetn)
      (s_reg.chan_sel != 4'h0) |=> $stable(s_reg.duty[0]) && $stable(s_reg.cfg[0]);
   endproperty
   a_other_chan: assert property (p_other_chan) else $error("unselected channel changed");

   property p_win_read;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[7:0] == 8'h04 && !s_reg.wr_pend && chan_ok
         && s_reg.reg_sel == 2'h0)
         |=> hrdata == {16'h0000, s_reg.duty[$past(s_reg.chan_sel)]} && $stable(s_reg.duty);
   endproperty
   a_win_read: assert property (p_win_read) else $error("window read wrong");

   property p_dac_loc;
      @(posedge hclk) disable iff (!hresetn)
      (!s_reg.cfg[0][13] && $stable(s_reg.cfg[0])) |=> pwm_pin[0] == $past(wave[0])
         && pwm_alt_pin[0] == 1'b0;
   endproperty
   a_dac_loc: assert property (p_dac_loc) else $error("channel 0 on wrong pin");

   property p_alternate_pin_location;
      @(posedge hclk) disable iff (!hresetn)
      (s_reg.cfg[3][13] && $stable(s_reg.cfg[3])) |=> pwm_alt_pin[3] == $past(wave[3])
         && pwm_pin[3] == 1'b0;
   endproperty
   a_alternate_pin_location: assert property (p_alternate_pin_location) else $error("channel 3 not on alternate pin");

   property p_invert_off;
      @(posedge hclk) disable iff (!hresetn)
      (s_reg.master_en && s_reg.cfg[8][12] && s_reg.cfg[8][15] && s_reg.duty[8] == 16'h0000)
         [*3] |-> pwm_pin[8] == 1'b1;
   endproperty
   a_invert_off: assert property (p_invert_off) else $error("inverted zero duty not high");

   property p_master_off;
      @(posedge hclk) disable iff (!hresetn)
      (!s_reg.master_en) [*3] |-> pwm_pin == 10'h000 && pwm_alt_pin == 8'h00;
   endproperty
   a_master_off: assert property (p_master_off) else $error("output with master off");

   property p_cfg_read;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[7:0] == 8'h04 && !s_reg.wr_pend && chan_ok
         && s_reg.reg_sel == 2'h1)
         |=> hrdata == {16'h0000, s_reg.cfg[$past(s_reg.chan_sel)]} && $stable(s_reg.cfg);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

   property p_bad_sel;
      @(posedge hclk) disable iff (!hresetn)
      (s_reg.wr_pend && s_reg.wr_addr == 8'h04 && (!chan_ok || s_reg.reg_sel[1]))
         |=> $stable(s_reg.duty) && $stable(s_reg.cfg);
   endproperty
   a_bad_sel: assert property (p_bad_sel) else $error("refused select changed a word");

   property p_status;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[7:0] == 8'h08) |=> hrdata == {22'h00_0000, $past(wave)};
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

endmodule

`default_nettype wire

// ---- core/pwm_channel.sv ----
/*
 * one pwm channel: frame counter, duty compare, enable and polarity.
 * assumes ticks arrive in the hclk domain, one cycle each.
 */
`include "pwm_cfg_consts.svh"
`default_nettype none

module pwm_channel (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // settings
   input wire logic [15:0] duty,
   input wire logic [15:0] cfg,
   input wire logic master_en,
   // count enables from the sources
   input wire logic periph_tick,
   input wire logic ext_tick,
   // wave
   output logic wave
);

   pwm_cfg_pkg::chan_state_type s_reg, s_next;
   logic [15:0] mask;
   logic active;
   logic tick;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      mask = pwm_cfg_pkg::depth_mask(cfg[`CFG_DEPTH_LSB +: 4]);
      active = cfg[`CFG_ENABLE_BIT] & master_en;
      unique case (cfg[`CFG_CLK_SRC_LSB +: 2])
         `CLK_SRC_CORE: tick = 1'b1;
         `CLK_SRC_PERIPH: tick = periph_tick;
         default: tick = ext_tick;
      endcase
      s_next = s_reg;
      if (!active) begin
         // idle channel holds its frame at the start so it resumes cleanly
         s_next.count = `WORD_RESET;
         s_next.out = 1'b0;
      end else begin
         if (tick) begin
            s_next.count = ((s_reg.count & mask) == mask) ? `WORD_RESET
                           : ((s_reg.count + 16'h0001) & mask);
         end else begin
            // a resolution cut while running on a slow source must not leave
            // count bits above the new depth
            s_next.count = s_reg.count & mask;
         end
         // compare only the active bits of duty and count
         s_next.out = ((s_reg.count & mask) < (duty & mask)) ^ cfg[`CFG_POLARITY_BIT];
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wave = s_reg.out;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_chan_off;
      @(posedge hclk) disable iff (!hresetn)
      !(cfg[`CFG_ENABLE_BIT] && master_en) |=> (s_reg.out == 1'b0) && (s_reg.count == 16'h0000);
   endproperty
   a_chan_off: assert property (p_chan_off) else $error("disabled channel not idle");

   property p_chan_depth;
      @(posedge hclk) disable iff (!hresetn)
      (cfg[`CFG_ENABLE_BIT] && master_en) |=> ((s_reg.count & ~$past(mask)) == 16'h0000);
   endproperty
   a_chan_depth: assert property (p_chan_depth) else $error("count beyond resolution");

   property p_chan_hold;
      @(posedge hclk) disable iff (!hresetn)
      (cfg[`CFG_ENABLE_BIT] && master_en && cfg[9] && !ext_tick && $stable(cfg))
         |=> $stable(s_reg.count);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("counted without a tick");

endmodule

`default_nettype wire

// ---- core/README_unused.sv ----
`default_nettype none
`default_nettype wire

// ---- verification/tb_pwm_cfg_top.sv ----
/*
 * self-checking bench for the pwm indirect configuration block: bus access
 * through the window, reset values, refused selects and the pin waveforms.
 * assumes the constants header is on the include path and one ahb master.
 */
`include "pwm_cfg_consts.svh"
`default_nettype none

module tb_pwm_cfg_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // signals
   // ***************************************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic periph_tick = 1'b0;
   logic ext_clk_pin = 1'b0;
   logic [`NUM_CH-1:0] pwm_pin;
   logic [`NUM_DAC_CH-1:0] pwm_alt_pin;
   logic [7:0] tcnt = 8'h00;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;

   // the one slave's ready is the bus's ready
   assign hready = hreadyout;

   pwm_cfg_top pwm_cfg_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .periph_tick(periph_tick), .ext_clk_pin(ext_clk_pin),
      .pwm_pin(pwm_pin), .pwm_alt_pin(pwm_alt_pin));

   always #10 hclk = ~hclk;

   // tick sources run free: a pulse every second cycle, an edge every eighth
   always @(posedge hclk) begin
      tcnt <= tcnt + 8'h01;
      periph_tick <= tcnt[0];
      ext_clk_pin <= tcnt[2];
   end

   // hang guard: the whole run needs well under half this many cycles
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         close_out();
      end
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single word transfer; waits on ready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask

   task automatic sel(input logic [3:0] c, input logic [1:0] s, input logic m);
      logic [31:0] d;
      bus(1'b1, `PWM_ADDR_CTRL, {23'h00_0000, m, c, 2'h0, s}, d);
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic check_reset();
      logic [31:0] d;
      chk("pins after reset", {14'h0000, pwm_alt_pin, pwm_pin}, 32'h0000_0000);
      for (int c = 0; c < `NUM_CH; c++) begin
         for (int s = 0; s < 2; s++) begin
            sel(4'(c), 2'(s), 1'b0);
            bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
            chk("local word after reset", d, 32'h0000_0000);
         end
      end
   endtask

   // distinct values in every channel catch a write landing in the wrong word
   task automatic check_access();
      logic [31:0] d;
      for (int c = 0; c < `NUM_CH; c++) begin
         sel(4'(c), `SEL_DUTY, 1'b0);
         bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_a500 + c, d);
         sel(4'(c), `SEL_CONFIG, 1'b0);
         bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_2300 + c, d); // reserved bits left zero
      end
      for (int c = `NUM_CH - 1; c >= 0; c--) begin
         sel(4'(c), `SEL_DUTY, 1'b0);
         bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
         chk("duty word", d, 32'h0000_a500 + c);
         bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
         chk("duty word reread", d, 32'h0000_a500 + c);
         sel(4'(c), `SEL_CONFIG, 1'b0);
         bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
         chk("config word", d, 32'h0000_2300 + c);
      end
   endtask

   // out-of-range selects and unmapped places must not disturb real words
   task automatic check_refused();
      logic [31:0] d;
      sel(4'ha, `SEL_DUTY, 1'b0);
      bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_ffff, d);
      bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      chk("channel ten window", d, 32'h0000_0000);
      sel(4'h3, 2'h2, 1'b0);
      bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_ffff, d);
      bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      chk("unbuilt word select", d, 32'h0000_0000);
      bus(1'b1, 8'h0c, 32'hffff_ffff, d);
      bus(1'b0, 8'h0c, 32'h0000_0000, d);
      chk("unmapped read", d, 32'h0000_0000);
      for (int s = 0; s < 2; s++) begin
         sel(4'h3, 2'(s), 1'b0);
         bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
         chk("word after refused writes", d, s == 0 ? 32'h0000_a503 : 32'h0000_2303);
      end
      bus(1'b0, `PWM_ADDR_STATUS, 32'h0000_0000, d);
      chk("status with all disabled", d, 32'h0000_0000);
   endtask

   // program channel 0 from a disabled state, then count high cycles over
   // whole frames so the count does not depend on where the frame starts
   task automatic wave(input logic m, input logic [15:0] cfg, input logic [15:0] duty,
                       input int n, input int e_pin, input int e_alt);
      logic [31:0] d;
      int hp;
      int ha;
      sel(4'h0, `SEL_CONFIG, m);
      bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      sel(4'h0, `SEL_DUTY, m);
      bus(1'b1, `PWM_ADDR_WINDOW, {16'h0000, duty}, d);
      sel(4'h0, `SEL_CONFIG, m);
      bus(1'b1, `PWM_ADDR_WINDOW, {16'h0000, cfg}, d);
      repeat (32) @(posedge hclk);
      hp = 0;
      ha = 0;
      repeat (n) begin
         @(posedge hclk);
         hp = hp + ((pwm_pin[0] === 1'b1) ? 1 : 0);
         ha = ha + ((pwm_alt_pin[0] === 1'b1) ? 1 : 0);
      end
      chk("default pin high cycles", 32'(hp), 32'(e_pin));
      chk("alternate pin high cycles", 32'(ha), 32'(e_alt));
      chk("other channel pins", {16'h0000, pwm_alt_pin[7:1], pwm_pin[9:1]},
          32'h0000_0000);
   endtask

   task automatic check_waves();
      // duty upper bits set on purpose: only the low resolution bits count
      wave(1'b1, 16'h1000, 16'hffc0, 256, 128, 0);
      wave(1'b1, 16'h1001, 16'hffc0, 512, 384, 0);
      wave(1'b1, 16'h1002, 16'hffc0, 1024, 896, 0);
      wave(1'b1, 16'h9000, 16'h0020, 256, 192, 0);
      wave(1'b1, 16'h3000, 16'h0020, 256, 0, 64);
      wave(1'b1, 16'h8000, 16'h0020, 256, 0, 0);
      wave(1'b0, 16'h1000, 16'h0020, 256, 0, 0);
      wave(1'b1, 16'h1100, 16'h0020, 512, 128, 0);
      wave(1'b1, 16'h1200, 16'h0020, 2048, 512, 0);
   endtask

   // channel 8 inverted at zero duty sits high; a reset in mid-run clears the pins, channel 8's config word and channel 3's duty word
   task automatic check_inv_reset();
      logic [31:0] d;
      sel(4'h0, `SEL_CONFIG, 1'b1);
      bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      sel(4'h8, `SEL_DUTY, 1'b1);
      bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      sel(4'h8, `SEL_CONFIG, 1'b1);
      bus(1'b1, `PWM_ADDR_WINDOW, 32'h0000_9000, d);
      repeat (8) @(posedge hclk);
      chk("inverted zero duty pins", {14'h0000, pwm_alt_pin, pwm_pin}, 32'h0000_0100);
      bus(1'b0, `PWM_ADDR_STATUS, 32'h0000_0000, d);
      chk("status inverted channel", d, 32'h0000_0100);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("pins in reset", {14'h0000, pwm_alt_pin, pwm_pin}, 32'h0000_0000);
      hresetn <= 1'b1;
      sel(4'h8, `SEL_CONFIG, 1'b1);
      bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      chk("config word after reset", d, 32'h0000_0000);
      sel(4'h3, `SEL_DUTY, 1'b0);
      bus(1'b0, `PWM_ADDR_WINDOW, 32'h0000_0000, d);
      chk("duty word after reset", d, 32'h0000_0000);
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      check_reset();
      check_access();
      check_refused();
      check_waves();
      check_inv_reset();
      close_out();
   end

endmodule

`default_nettype wire
